// ==== hw/rct_pin_sync.sv ====
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps
module rct_pin_sync
	import rct_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic pin,
	output logic level_q,
	output logic fall_q,
	output logic rise_q
);
	logic s1_q, s2_q, s3_q;
	logic level_d, fall_d, rise_d;

	// A new level is accepted only once the second and third stages agree
	always_comb begin
		level_d = level_q;
		if (s2_q == s3_q) begin
			level_d = s3_q;
		end
		fall_d = level_q & ~level_d;
		rise_d = ~level_q & level_d;
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_q <= 1'b0;
			fall_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= level_d;
			fall_q <= fall_d;
			rise_q <= rise_d;
		end
	end
endmodule

// ==== hw/rct_timer.sv ====
// Reloadable 16-bit capture timer with byte-wide special-function registers
`timescale 1ns/100ps
// Summary of operation
// - Down in reload: match reload, load all ones
// - Up in reload: past all ones, load reload
// - Toggle-capable instance inverts output on each reload-mode wrap
// - Toggle bit reads output level, write forces it
// - Wrap flag set on wraps, sticky until cleared
// - External flag set on enabled falling-edge event
// - External enable low ignores control input edges
// - Capture mode falling edge copies counter out
// - Reload mode falling edge reloads counter, flags
// - Down enable: control input low counts down
// - Run bit low holds counter stopped
// - Source select: prescaled clock or count pin
// - Capture/reload select: zero reload, one capture
// - Clock mode: div12, sys, ext div8, div2
// - Reload/capture pair holds capture or reload value
// - Each instance samples shared pins independently
// - Upper counter byte is its own register
// - Reload mode external flag toggles on each wrap
module rct_timer
	import rct_pkg::*;
#(
	parameter bit TOGGLE_CAPABLE = 1'b1
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire rct_sfr_req_t sfr_req,
	output logic [7:0] sfr_rdata_q,
	output logic sfr_rvalid_q,
	input wire logic external_count_pin,
	input wire logic external_control_input,
	input wire logic external_clock,
	output logic toggle_pin_q,
	output logic timer_request_q
);
	logic cnt_fall, ctl_level, ctl_fall, xclk_rise;
	logic [3:0] div12_q, div12_d;
	logic div2_q, div2_d;
	logic [2:0] div8_q, div8_d;
	logic div8_tick_q, div8_tick_d;
	rct_ctl_t ctl_q, ctl_d;
	rct_cfg_t cfg_q, cfg_d;
	logic wrap_flag_q, wrap_flag_d;
	logic ext_flag_q, ext_flag_d;
	logic toggle_q, toggle_d;
	logic [15:0] count_q, count_d;
	logic [15:0] rcap_q, rcap_d;
	logic [7:0] rdata_d;
	logic rvalid_d, toggle_pin_d, request_d;
	logic clk_tick, tick, down, ext_evt, wrap, base_ext;
	logic wr_ctl, wr_cfg, wr_rl, wr_rh, wr_cl, wr_ch;

	function automatic logic is_write(input rct_sfr_req_t req, input logic [7:0] addr);
		return req.wr_en && (req.addr == addr);
	endfunction

	// Each instance keeps its own synchronisers on the shared pins
	rct_pin_sync u_count_sync (.clock(clock), .reset_n(reset_n), .pin(external_count_pin),
		.level_q(), .fall_q(cnt_fall), .rise_q());
	rct_pin_sync u_ctl_sync (.clock(clock), .reset_n(reset_n), .pin(external_control_input),
		.level_q(ctl_level), .fall_q(ctl_fall), .rise_q());
	rct_pin_sync u_xclk_sync (.clock(clock), .reset_n(reset_n), .pin(external_clock),
		.level_q(), .fall_q(), .rise_q(xclk_rise));

	// Prescalers
	always_comb begin
		div12_d = (div12_q == RCT_DIV12_LAST) ? RCT_DIV12_ZERO : div12_q + RCT_DIV12_STEP;
		div2_d = ~div2_q;
		div8_d = div8_q;
		div8_tick_d = 1'b0;
		if (xclk_rise) begin
			div8_d = div8_q + RCT_DIV8_STEP;
			div8_tick_d = (div8_q == RCT_DIV8_LAST);
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			div12_q <= RCT_DIV12_ZERO;
			div2_q <= 1'b0;
			div8_q <= RCT_DIV8_ZERO;
			div8_tick_q <= 1'b0;
		end else begin
			div12_q <= div12_d;
			div2_q <= div2_d;
			div8_q <= div8_d;
			div8_tick_q <= div8_tick_d;
		end
	end

	always_comb begin
		unique case (cfg_q.clock_mode)
			RCT_CLK_DIV12: clk_tick = (div12_q == RCT_DIV12_LAST);
			RCT_CLK_SYS: clk_tick = 1'b1;
			RCT_CLK_EXT_DIV8: clk_tick = div8_tick_q;
			RCT_CLK_DIV2: clk_tick = div2_q;
		endcase
	end

	assign tick = ctl_q.run && (ctl_q.count_src ? cnt_fall : clk_tick);
	assign down = cfg_q.down_en && !ctl_level;
	assign ext_evt = ctl_q.ext_enable && !cfg_q.down_en && ctl_fall;

	assign wr_ctl = is_write(sfr_req, RCT_ADDR_CONTROL);
	assign wr_cfg = is_write(sfr_req, RCT_ADDR_CONFIG);
	assign wr_rl = is_write(sfr_req, RCT_ADDR_RCAP_LOW);
	assign wr_rh = is_write(sfr_req, RCT_ADDR_RCAP_HIGH);
	assign wr_cl = is_write(sfr_req, RCT_ADDR_COUNT_LOW);
	assign wr_ch = is_write(sfr_req, RCT_ADDR_COUNT_HIGH);

	// Counter, reload/capture pair, flags and toggle
	always_comb begin
		count_d = count_q;
		rcap_d = rcap_q;
		wrap = 1'b0;
		if (tick) begin
			if (down) begin
				if (!ctl_q.capture && count_q == rcap_q) begin
					count_d = RCT_ALL_ONES;
					wrap = 1'b1;
				end else begin
					count_d = count_q - RCT_ONE;
					wrap = ctl_q.capture && (count_q == RCT_ZERO);
				end
			end else if (count_q == RCT_ALL_ONES) begin
				count_d = ctl_q.capture ? RCT_ZERO : rcap_q;
				wrap = 1'b1;
			end else begin
				count_d = count_q + RCT_ONE;
			end
		end
		if (ext_evt) begin
			if (ctl_q.capture) begin
				rcap_d = count_q;
			end else begin
				count_d = rcap_q;
				wrap = 1'b0;
			end
		end
		if (wr_rl && !(ext_evt && ctl_q.capture)) begin
			rcap_d[7:0] = sfr_req.wdata;
		end
		if (wr_rh && !(ext_evt && ctl_q.capture)) begin
			rcap_d[15:8] = sfr_req.wdata;
		end
		if (wr_cl) begin
			count_d[7:0] = sfr_req.wdata;
		end
		if (wr_ch) begin
			count_d[15:8] = sfr_req.wdata;
		end
		ctl_d = ctl_q;
		if (wr_ctl) begin
			ctl_d = '{ext_enable: sfr_req.wdata[RCT_CTL_EXT_ENABLE], run: sfr_req.wdata[RCT_CTL_RUN],
				count_src: sfr_req.wdata[RCT_CTL_COUNT_SRC], capture: sfr_req.wdata[RCT_CTL_CAPTURE]};
		end
		cfg_d = cfg_q;
		if (wr_cfg) begin
			cfg_d = '{clock_mode: sfr_req.wdata[RCT_CFG_MODE_HIGH:RCT_CFG_MODE_LOW],
				out_en: sfr_req.wdata[RCT_CFG_OUT_EN], down_en: sfr_req.wdata[RCT_CFG_DOWN_EN]};
		end
		// Hardware set takes priority over a software clear in the same cycle
		wrap_flag_d = wrap | (wr_ctl ? sfr_req.wdata[RCT_CTL_WRAP_FLAG] : wrap_flag_q);
		base_ext = wr_ctl ? sfr_req.wdata[RCT_CTL_EXT_FLAG] : ext_flag_q;
		ext_flag_d = ext_evt | (base_ext ^ (wrap & ~ctl_q.capture));
		toggle_d = toggle_q;
		if (wr_cfg) begin
			toggle_d = sfr_req.wdata[RCT_CFG_TOGGLE];
		end else if (TOGGLE_CAPABLE && wrap && !ctl_q.capture && cfg_q.out_en) begin
			toggle_d = ~toggle_q;
		end
		toggle_pin_d = TOGGLE_CAPABLE && cfg_d.out_en && toggle_d;
		request_d = wrap_flag_d | (ext_flag_d & ctl_d.capture);
	end

	// Read port: unmapped addresses read as zero
	always_comb begin
		rvalid_d = sfr_req.rd_en;
		rdata_d = RCT_RESET_BYTE;
		if (sfr_req.rd_en) begin
			unique case (sfr_req.addr)
				RCT_ADDR_CONTROL: rdata_d = {wrap_flag_q, ext_flag_q, 2'h0, ctl_q.ext_enable, ctl_q.run,
					ctl_q.count_src, ctl_q.capture};
				RCT_ADDR_CONFIG: rdata_d = {3'h0, cfg_q.clock_mode, toggle_q, cfg_q.out_en,
					cfg_q.down_en};
				RCT_ADDR_RCAP_LOW: rdata_d = rcap_q[7:0];
				RCT_ADDR_RCAP_HIGH: rdata_d = rcap_q[15:8];
				RCT_ADDR_COUNT_LOW: rdata_d = count_q[7:0];
				RCT_ADDR_COUNT_HIGH: rdata_d = count_q[15:8];
				default: rdata_d = RCT_RESET_BYTE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= RCT_RESET_WORD;
			rcap_q <= RCT_RESET_WORD;
			ctl_q <= '0;
			cfg_q <= '0;
			wrap_flag_q <= 1'b0;
			ext_flag_q <= 1'b0;
			toggle_q <= 1'b0;
			toggle_pin_q <= 1'b0;
			timer_request_q <= 1'b0;
			sfr_rdata_q <= RCT_RESET_BYTE;
			sfr_rvalid_q <= 1'b0;
		end else begin
			count_q <= count_d;
			rcap_q <= rcap_d;
			ctl_q <= ctl_d;
			cfg_q <= cfg_d;
			wrap_flag_q <= wrap_flag_d;
			ext_flag_q <= ext_flag_d;
			toggle_q <= toggle_d;
			toggle_pin_q <= toggle_pin_d;
			timer_request_q <= request_d;
			sfr_rdata_q <= rdata_d;
			sfr_rvalid_q <= rvalid_d;
		end
	end

	logic cnt_wr;
	assign cnt_wr = wr_cl | wr_ch;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_down_reload_match: assert property (tick && down && !ctl_q.capture && count_q == rcap_q && !ext_evt
		&& !cnt_wr |=> count_q == RCT_ALL_ONES && wrap_flag_q)
		else $error("Reload-mode underflow did not load all ones");
	a_up_reload_load: assert property (tick && !down && !ctl_q.capture && count_q == RCT_ALL_ONES
		&& !ext_evt && !cnt_wr |=> count_q == $past(rcap_q) && wrap_flag_q)
		else $error("Reload-mode overflow did not load reload value");
	a_toggle_on_wrap: assert property (wrap && !ctl_q.capture && cfg_q.out_en && !wr_cfg
		|=> toggle_q != $past(toggle_q) && toggle_pin_q == toggle_q)
		else $error("Toggle output did not invert on wrap");
	a_toggle_force: assert property (wr_cfg |=> toggle_q == $past(sfr_req.wdata[RCT_CFG_TOGGLE]))
		else $error("Toggle write did not force the output level");
	a_wrap_flag_sticky: assert property (wrap_flag_q && !wr_ctl |=> wrap_flag_q)
		else $error("Wrap flag cleared without software");
	a_capture_down_wrap: assert property (tick && down && ctl_q.capture && count_q == RCT_ZERO
		&& !cnt_wr |=> count_q == RCT_ALL_ONES && wrap_flag_q)
		else $error("Capture-mode underflow mishandled");
	a_ext_ignored: assert property (!ctl_q.ext_enable |-> !ext_evt)
		else $error("Control edge acted while external enable low");
	a_capture_copy: assert property (ext_evt && ctl_q.capture |=> rcap_q == $past(count_q) && ext_flag_q)
		else $error("Capture did not copy the counter");
	a_ext_reload: assert property (ext_evt && !ctl_q.capture && !cnt_wr
		|=> count_q == $past(rcap_q) && ext_flag_q)
		else $error("External reload mishandled");
	a_run_hold: assert property (!ctl_q.run && !ext_evt && !cnt_wr |=> $stable(count_q))
		else $error("Counter moved while stopped");
	a_set_wins: assert property (wrap && wr_ctl |=> wrap_flag_q)
		else $error("Software clear beat hardware set");

	c_reload_overflow: cover property (tick && !down && !ctl_q.capture && count_q == RCT_ALL_ONES);
	c_reload_underflow: cover property (tick && down && !ctl_q.capture && count_q == rcap_q);
	c_capture_event: cover property (ext_evt && ctl_q.capture);
	c_toggle_run: cover property (toggle_pin_q ##[1:300] !toggle_pin_q);
endmodule

// ==== inc/rct_pkg.sv ====
// Register map, field positions, dividers and carrier types of the reloadable capture timer
package rct_pkg;
	localparam logic [7:0] RCT_ADDR_CONTROL = 8'hC8;
	localparam logic [7:0] RCT_ADDR_CONFIG = 8'hC9;
	localparam logic [7:0] RCT_ADDR_RCAP_LOW = 8'hCA;
	localparam logic [7:0] RCT_ADDR_RCAP_HIGH = 8'hCB;
	localparam logic [7:0] RCT_ADDR_COUNT_LOW = 8'hCC;
	localparam logic [7:0] RCT_ADDR_COUNT_HIGH = 8'hCD;

	localparam logic [7:0] RCT_RESET_BYTE = 8'h00;
	localparam logic [15:0] RCT_RESET_WORD = 16'h0000;
	localparam logic [15:0] RCT_ALL_ONES = 16'hFFFF;
	localparam logic [15:0] RCT_ZERO = 16'h0000;
	localparam logic [15:0] RCT_ONE = 16'h0001;

	// Control register bit positions
	localparam int RCT_CTL_WRAP_FLAG = 7;
	localparam int RCT_CTL_EXT_FLAG = 6;
	localparam int RCT_CTL_EXT_ENABLE = 3;
	localparam int RCT_CTL_RUN = 2;
	localparam int RCT_CTL_COUNT_SRC = 1;
	localparam int RCT_CTL_CAPTURE = 0;

	// Config register bit positions
	localparam int RCT_CFG_MODE_HIGH = 4;
	localparam int RCT_CFG_MODE_LOW = 3;
	localparam int RCT_CFG_TOGGLE = 2;
	localparam int RCT_CFG_OUT_EN = 1;
	localparam int RCT_CFG_DOWN_EN = 0;

	// Clock mode field codes
	localparam logic [1:0] RCT_CLK_DIV12 = 2'h0;
	localparam logic [1:0] RCT_CLK_SYS = 2'h1;
	localparam logic [1:0] RCT_CLK_EXT_DIV8 = 2'h2;
	localparam logic [1:0] RCT_CLK_DIV2 = 2'h3;

	// Divider terminal counts
	localparam logic [3:0] RCT_DIV12_LAST = 4'hB;
	localparam logic [3:0] RCT_DIV12_ZERO = 4'h0;
	localparam logic [3:0] RCT_DIV12_STEP = 4'h1;
	localparam logic [2:0] RCT_DIV8_LAST = 3'h7;
	localparam logic [2:0] RCT_DIV8_ZERO = 3'h0;
	localparam logic [2:0] RCT_DIV8_STEP = 3'h1;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
	} rct_sfr_req_t;

	typedef struct packed {
		logic ext_enable;
		logic run;
		logic count_src;
		logic capture;
	} rct_ctl_t;

	typedef struct packed {
		logic [1:0] clock_mode;
		logic out_en;
		logic down_en;
	} rct_cfg_t;
endpackage

// ==== verification/rct_pin_model.sv ====
// Behavioural model of the count, control and external clock pins
`timescale 1ns/100ps
module rct_pin_model (
	input wire logic clock,
	output logic count_pin,
	output logic control_pin,
	output logic ext_clock
);
	initial begin
		count_pin = 1'b1;
		control_pin = 1'b1;
		ext_clock = 1'b0;
	end
	// Free-running oscillator of five system clock periods, its edges falling on system clock edges
	always #20 ext_clock = ~ext_clock;
	// Each level is held long enough for the pin synchroniser to see it
	task automatic count_edges(input int n);
		repeat (n) begin
			@(negedge clock) count_pin = 1'b0;
			repeat (6) @(negedge clock);
			count_pin = 1'b1;
			repeat (6) @(negedge clock);
		end
	endtask
	task automatic set_control(input logic level);
		@(negedge clock) control_pin = level;
		repeat (8) @(negedge clock);
	endtask
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the reloadable capture timer
`timescale 1ns/100ps
module testbench;
	import rct_pkg::*;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	rct_sfr_req_t sfr_req = '0;
	logic [7:0] sfr_rdata_q;
	logic sfr_rvalid_q, toggle_pin_q, timer_request_q;
	logic count_pin, control_pin, ext_clock;
	logic [7:0] rd;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;
	always #4 clock = ~clock;
	rct_timer dut_u (.clock(clock), .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata_q(sfr_rdata_q),
		.sfr_rvalid_q(sfr_rvalid_q), .external_count_pin(count_pin), .external_control_input(control_pin),
		.external_clock(ext_clock), .toggle_pin_q(toggle_pin_q), .timer_request_q(timer_request_q));
	rct_pin_model pins_u (.clock(clock), .count_pin(count_pin), .control_pin(control_pin), .ext_clock(ext_clock));
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures = failures + 1;
			$display("wrong value at %0t: run timed out", $time);
			complete_run();
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] expected, input string what);
		samples_checked++;
		if (seen !== expected) begin
			failures++;
			$display("wrong value at %0t: %s saw %0h expected %0h", $time, what, seen, expected);
		end
	endtask
	task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
		@(negedge clock);
		sfr_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: addr, wdata: data};
		@(negedge clock);
		sfr_req = '0;
	endtask
	task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
		@(negedge clock);
		sfr_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: addr, wdata: 8'h00};
		@(negedge clock);
		sfr_req = '0;
		if (sfr_rvalid_q !== 1'b1) @(negedge clock);
		data = (sfr_rvalid_q === 1'b1) ? sfr_rdata_q : 8'hXX;
	endtask
	task automatic expect_reg(input logic [7:0] addr, input logic [7:0] expected, input string what);
		sfr_read(addr, rd);
		check({8'h00, rd}, {8'h00, expected}, what);
	endtask
	task automatic write_word(input logic [7:0] low_addr, input logic [15:0] value);
		sfr_write(low_addr, value[7:0]);
		sfr_write(low_addr + 8'h01, value[15:8]);
	endtask
	task automatic test_reset_values();
		for (int a = 'hC8; a <= 'hCD; a++) begin
			expect_reg(8'(a), 8'h00, "reset value");
		end
		expect_reg(8'hC0, 8'h00, "unmapped");
		sfr_write(RCT_ADDR_COUNT_HIGH, 8'h5A);
		expect_reg(RCT_ADDR_COUNT_HIGH, 8'h5A, "upper count byte");
	endtask
	task automatic test_up_reload();
		// Reload of 0xFFFE gives a wrap every second count edge
		write_word(RCT_ADDR_RCAP_LOW, 16'hFFFE);
		write_word(RCT_ADDR_COUNT_LOW, 16'hFFFD);
		sfr_write(RCT_ADDR_CONFIG, 8'h06);
		@(negedge clock);
		check(toggle_pin_q, 16'h0001, "forced high");
		sfr_write(RCT_ADDR_CONFIG, 8'h02);
		@(negedge clock);
		check(toggle_pin_q, 16'h0000, "forced low");
		sfr_write(RCT_ADDR_CONTROL, 8'h06);
		pins_u.count_edges(3);
		expect_reg(RCT_ADDR_COUNT_LOW, 8'hFE, "reload low");
		expect_reg(RCT_ADDR_COUNT_HIGH, 8'hFF, "reload high");
		expect_reg(RCT_ADDR_CONTROL, 8'hC6, "flags after wrap");
		expect_reg(RCT_ADDR_CONFIG, 8'h06, "toggle state");
		check(toggle_pin_q, 16'h0001, "toggled");
		check(timer_request_q, 16'h0001, "request");
		sfr_write(RCT_ADDR_CONTROL, 8'h06);
		@(negedge clock);
		check(timer_request_q, 16'h0000, "cleared");
		sfr_write(RCT_ADDR_CONTROL, 8'h00);
		sfr_write(RCT_ADDR_CONFIG, 8'h00);
	endtask
	task automatic test_down_reload();
		sfr_write(RCT_ADDR_CONFIG, 8'h01);
		pins_u.set_control(1'b0);
		write_word(RCT_ADDR_RCAP_LOW, 16'h0010);
		write_word(RCT_ADDR_COUNT_LOW, 16'h0012);
		sfr_write(RCT_ADDR_CONTROL, 8'h0E);
		pins_u.count_edges(3);
		expect_reg(RCT_ADDR_COUNT_LOW, 8'hFF, "underflow low");
		expect_reg(RCT_ADDR_COUNT_HIGH, 8'hFF, "underflow high");
		expect_reg(RCT_ADDR_CONTROL, 8'hCE, "underflow flags");
		sfr_write(RCT_ADDR_CONTROL, 8'h00);
		sfr_write(RCT_ADDR_CONFIG, 8'h00);
		pins_u.set_control(1'b1);
	endtask
	task automatic test_capture();
		write_word(RCT_ADDR_COUNT_LOW, 16'h1234);
		write_word(RCT_ADDR_RCAP_LOW, 16'h0000);
		sfr_write(RCT_ADDR_CONTROL, 8'h03);
		pins_u.count_edges(2);
		expect_reg(RCT_ADDR_COUNT_LOW, 8'h34, "stopped");
		sfr_write(RCT_ADDR_CONTROL, 8'h07);
		pins_u.set_control(1'b0);
		pins_u.set_control(1'b1);
		expect_reg(RCT_ADDR_RCAP_LOW, 8'h00, "edge ignored");
		expect_reg(RCT_ADDR_CONTROL, 8'h07, "no flag");
		sfr_write(RCT_ADDR_CONTROL, 8'h0F);
		pins_u.count_edges(1);
		pins_u.set_control(1'b0);
		pins_u.set_control(1'b1);
		expect_reg(RCT_ADDR_RCAP_LOW, 8'h35, "capture low");
		expect_reg(RCT_ADDR_RCAP_HIGH, 8'h12, "capture high");
		expect_reg(RCT_ADDR_CONTROL, 8'h4F, "capture flag");
		check(timer_request_q, 16'h0001, "capture request");
		sfr_write(RCT_ADDR_CONTROL, 8'h00);
	endtask
	task automatic test_ext_reload();
		write_word(RCT_ADDR_RCAP_LOW, 16'hABCD);
		write_word(RCT_ADDR_COUNT_LOW, 16'h0005);
		sfr_write(RCT_ADDR_CONTROL, 8'h0E);
		pins_u.set_control(1'b0);
		pins_u.set_control(1'b1);
		expect_reg(RCT_ADDR_COUNT_LOW, 8'hCD, "reload low");
		expect_reg(RCT_ADDR_COUNT_HIGH, 8'hAB, "reload high");
		expect_reg(RCT_ADDR_CONTROL, 8'h4E, "reload flag");
		check(timer_request_q, 16'h0000, "no request");
		sfr_write(RCT_ADDR_CONTROL, 8'h00);
	endtask
	task automatic test_clock_modes();
		logic [7:0] ticks [4];
		ticks = '{8'h14, 8'hF0, 8'h06, 8'h78};
		for (int m = 0; m < 4; m++) begin
			write_word(RCT_ADDR_COUNT_LOW, 16'h0000);
			sfr_write(RCT_ADDR_CONFIG, {3'h0, 2'(m), 3'h0});
			expect_reg(RCT_ADDR_CONFIG, {3'h0, 2'(m), 3'h0}, "mode field");
			sfr_write(RCT_ADDR_CONTROL, 8'h04);
			repeat (238) @(negedge clock);
			sfr_write(RCT_ADDR_CONTROL, 8'h00);
			sfr_read(RCT_ADDR_COUNT_LOW, rd);
			check(rd >= ticks[m] - 8'h01 && rd <= ticks[m] + 8'h01, 16'h0001, "tick count");
		end
	endtask
	task automatic test_mid_reset();
		write_word(RCT_ADDR_COUNT_LOW, 16'h1255);
		sfr_write(RCT_ADDR_CONFIG, 8'h06);
		@(negedge clock);
		reset_n = 1'b0;
		repeat (2) @(negedge clock);
		check(toggle_pin_q, 16'h0000, "pin in reset");
		reset_n = 1'b1;
		expect_reg(RCT_ADDR_COUNT_LOW, 8'h00, "count after reset");
		expect_reg(RCT_ADDR_CONFIG, 8'h00, "config after reset");
	endtask
	initial begin
		repeat (16) @(negedge clock);
		reset_n = 1'b1;
		test_reset_values();
		test_up_reload();
		test_down_reload();
		test_capture();
		test_ext_reload();
		test_clock_modes();
		test_mid_reset();
		complete_run();
	end
endmodule
